/* rtl/vpas_cfg.svh */
// What this block does
// - access starts on strobe with select, ends on hold
// - strap caught at programming picks mode
// - row, hold, column setup, then column strobes
// - pipelining frees column address after hold time
// - write with column delay adds one edge
// - reads without extend option: enable follows column
// - host itself makes the vram write enable
// - mode 0 latch pulse with select sets request
// - mode 0 row strobes on clock edge when free
// - mode 0 hold request after first edge
// - select may drop once hold is asserted
// - hold release drops row strobes and acknowledge
// - column strobes end or stretch per extend option
// - latch input low by hold release period
// - pipelined next latch only after hold cycle
// - mode 1 select comes with strobe, on the same edge
// - mode 1 row strobes straight from strobe
// - mode 1 held off starts after busy clears
// - hold with or after strobe, carries access
// - only a fresh strobe starts an access
// - strobe and hold may be one wire
// - pipelined strobe reassertion requests next access
// - inputs synchronous to the system clock
`ifndef VPAS_CFG_SVH
`define VPAS_CFG_SVH

// ==========================================
// timing
`define VPAS_CLK_MHZ 250
`define VPAS_ROW_HOLD_NS 10
`define VPAS_COL_SETUP_NS 4
`define VPAS_COL_HOLD_NS 12
`define VPAS_PRECHARGE_NS 40
`define VPAS_ROW_HOLD_CYC ((`VPAS_ROW_HOLD_NS * `VPAS_CLK_MHZ + 999) / 1000)
`define VPAS_COL_SETUP_CYC ((`VPAS_COL_SETUP_NS * `VPAS_CLK_MHZ + 999) / 1000)
`define VPAS_COL_HOLD_CYC ((`VPAS_COL_HOLD_NS * `VPAS_CLK_MHZ + 999) / 1000)
`define VPAS_PRECHARGE_CYC ((`VPAS_PRECHARGE_NS * `VPAS_CLK_MHZ + 999) / 1000)

// ==========================================
// host register map
`define VPAS_REG_CTRL 4'h0
`define VPAS_REG_ADDR 4'h4
`define VPAS_REG_HOLD 4'h8
`define VPAS_REG_STATUS 4'hc
`define VPAS_CTRL_START 0
`define VPAS_CTRL_WRITE 1
`define VPAS_CTRL_MODE1 2
`define VPAS_CTRL_EXTEND 3
`define VPAS_ADDR_BANK_LSB 22
`define VPAS_ADDR_BYTE_LSB 24
`define VPAS_STATUS_BUSY 0
`define VPAS_STATUS_ACKS_LSB 8
`define VPAS_HOLD_RST 8'h04

`endif

/* rtl/vpas_pkg.sv */
package vpas_pkg;
  // ==========================================
  // types
  typedef enum logic [5:0] {
    VPAS_D_IDLE = 6'h01,
    VPAS_D_ROW = 6'h02,
    VPAS_D_COLSU = 6'h04,
    VPAS_D_COLDLY = 6'h08,
    VPAS_D_COL = 6'h10,
    VPAS_D_EXTEND = 6'h20
  } vpas_dev_state_t;

  typedef enum logic [2:0] {
    VPAS_H_IDLE = 3'h1,
    VPAS_H_STROBE = 3'h2,
    VPAS_H_HOLD = 3'h4
  } vpas_host_state_t;

  typedef struct packed {
    logic mode1;
    logic pipeline;
    logic col_delay;
    logic cas_ext_opt;
    logic ack_en;
  } vpas_cfg_t;
endpackage

/* rtl/vpas_link_if.sv */
interface vpas_link_if #(
  parameter int HW = 11,
  parameter int NR = 4,
  parameter int NC = 4
);
  logic address_strobe;
  logic chip_select;
  logic access_hold_request;
  logic write_indicator;
  logic vram_write_enable;
  logic [2*HW-1:0] address;
  logic [$clog2(NR)-1:0] bank_select;
  logic [NC-1:0] byte_select;
  logic [NC-1:0] cas_extend_inputs;
  logic [NR-1:0] row_strobe;
  logic [NC-1:0] col_strobe;
  logic [HW-1:0] muxed_address_out;
  logic transfer_output_enable;
  logic transfer_acknowledge;

  modport device (
    input address_strobe, chip_select, access_hold_request, write_indicator,
    input address, bank_select, byte_select, cas_extend_inputs,
    output row_strobe, col_strobe, muxed_address_out, transfer_output_enable, transfer_acknowledge
  );
  modport host (
    output address_strobe, chip_select, access_hold_request, write_indicator, vram_write_enable,
    output address, bank_select, byte_select, cas_extend_inputs,
    input row_strobe, col_strobe, muxed_address_out, transfer_output_enable, transfer_acknowledge
  );
endinterface

/* rtl/vpas_down_timer.sv */
module vpas_down_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  import vpas_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } vpas_tmr_state_t;

  vpas_tmr_state_t state_reg;
  vpas_tmr_state_t state_next;

  // ==========================================
  // count down to zero
  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.cnt = value;
    end else if (state_reg.cnt != '0) begin
      state_next.cnt = state_reg.cnt - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign done = (state_reg.cnt == '0);
endmodule // vpas_down_timer

/* rtl/vpas_device.sv */
// The placing of the registers and the plain strobed port were chosen for this implementation.
`include "vpas_cfg.svh"

module vpas_device #(
  parameter int HW = 11,
  parameter int NR = 4,
  parameter int NC = 4,
  parameter int TW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // programming
  input wire logic program_load,
  input wire logic mode_select_strap,
  input wire logic pipeline_option,
  input wire logic column_delay_bit,
  input wire logic cas_extend_option,
  input wire logic ack_option,
  // arbitration
  input wire logic refresh_busy,
  input wire logic port_b_busy,
  input wire logic transfer_busy,
  // link
  vpas_link_if.device link
);
  import vpas_pkg::*;

  localparam int BW = $clog2(NR);

  typedef struct packed {
    vpas_dev_state_t st;
    vpas_cfg_t cfg;
    logic strobe_prev;
    logic req_latch;
    logic hold_seen;
    logic col_hold_done;
    logic [2*HW-1:0] pend_addr;
    logic [BW-1:0] pend_bank;
    logic [NC-1:0] pend_bytes;
    logic [2*HW-1:0] cur_addr;
    logic [NC-1:0] cur_bytes;
    logic [NR-1:0] row_strobe;
    logic [NC-1:0] col_strobe;
    logic [HW-1:0] q;
    logic toe;
    logic ack;
  } vpas_dev_reg_t;

  vpas_dev_reg_t state_reg;
  vpas_dev_reg_t state_next;

  logic ph_load;
  logic [TW-1:0] ph_value;
  logic ph_done;
  logic pre_load;
  logic pre_done;
  logic fresh;
  logic req_in;
  logic can_start;
  logic from_fresh;
  logic start;
  logic release_hold;
  logic finish;
  logic [NC-1:0] ext_cas;

  function automatic logic [NR-1:0] bank_decode(input logic [BW-1:0] b);
    logic [NR-1:0] r;
    r = '0;
    r[b] = 1'b1;
    return r;
  endfunction

  // ==========================================
  // timers
  vpas_down_timer #(.W(TW)) phase_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(ph_load),
    .value(ph_value),
    .done(ph_done)
  );

  vpas_down_timer #(.W(TW)) precharge_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(pre_load),
    .value(TW'(`VPAS_PRECHARGE_CYC)),
    .done(pre_done)
  );

  // ==========================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    ph_load = 1'b0;
    ph_value = '0;
    pre_load = 1'b0;
    finish = 1'b0;
    state_next.strobe_prev = link.address_strobe;
    if (program_load) begin
      state_next.cfg.mode1 = mode_select_strap;
      state_next.cfg.pipeline = pipeline_option;
      state_next.cfg.col_delay = column_delay_bit;
      state_next.cfg.cas_ext_opt = cas_extend_option;
      state_next.cfg.ack_en = ack_option;
    end
    // only a rising strobe with select counts as a request
    fresh = link.address_strobe & ~state_reg.strobe_prev;
    req_in = fresh & link.chip_select;
    can_start = (state_reg.st == VPAS_D_IDLE) & pre_done & ~refresh_busy & ~port_b_busy & ~transfer_busy;
    from_fresh = state_reg.cfg.mode1 & req_in & ~state_reg.req_latch;
    start = can_start & (state_reg.req_latch | from_fresh);
    // set wins over clear
    state_next.req_latch = (state_reg.req_latch & ~start) | (req_in & ~(start & from_fresh));
    if (req_in & ~(start & from_fresh)) begin
      state_next.pend_addr = link.address;
      state_next.pend_bank = link.bank_select;
      state_next.pend_bytes = link.byte_select;
    end
    release_hold = state_reg.hold_seen & ~link.access_hold_request;
    if (link.access_hold_request) begin
      state_next.hold_seen = 1'b1;
    end
    ext_cas = state_reg.col_strobe & link.cas_extend_inputs;
    case (state_reg.st)
      VPAS_D_IDLE: begin
        state_next.hold_seen = 1'b0;
        if (start) begin
          state_next.st = VPAS_D_ROW;
          state_next.hold_seen = link.access_hold_request;
          state_next.col_hold_done = 1'b0;
          ph_load = 1'b1;
          ph_value = TW'(`VPAS_ROW_HOLD_CYC);
          if (from_fresh) begin
            state_next.cur_addr = link.address;
            state_next.cur_bytes = link.byte_select;
            state_next.row_strobe = bank_decode(link.bank_select);
            state_next.q = link.address[2*HW-1:HW];
          end else begin
            state_next.cur_addr = state_reg.pend_addr;
            state_next.cur_bytes = state_reg.pend_bytes;
            state_next.row_strobe = bank_decode(state_reg.pend_bank);
            state_next.q = state_reg.pend_addr[2*HW-1:HW];
          end
        end
      end
      VPAS_D_ROW: begin
        if (release_hold) begin
          finish = 1'b1;
        end else if (ph_done) begin
          state_next.st = VPAS_D_COLSU;
          state_next.q = state_reg.cur_addr[HW-1:0];
          ph_load = 1'b1;
          ph_value = TW'(`VPAS_COL_SETUP_CYC);
        end
      end
      VPAS_D_COLSU: begin
        if (release_hold) begin
          finish = 1'b1;
        end else if (ph_done) begin
          if (link.write_indicator & state_reg.cfg.col_delay) begin
            state_next.st = VPAS_D_COLDLY;
          end else begin
            state_next.st = VPAS_D_COL;
            state_next.col_strobe = state_reg.cur_bytes;
            ph_load = 1'b1;
            ph_value = TW'(`VPAS_COL_HOLD_CYC);
          end
        end
      end
      VPAS_D_COLDLY: begin
        if (release_hold) begin
          finish = 1'b1;
        end else begin
          state_next.st = VPAS_D_COL;
          state_next.col_strobe = state_reg.cur_bytes;
          ph_load = 1'b1;
          ph_value = TW'(`VPAS_COL_HOLD_CYC);
        end
      end
      VPAS_D_COL: begin
        if (ph_done & state_reg.cfg.pipeline & ~state_reg.col_hold_done) begin
          state_next.col_hold_done = 1'b1;
          state_next.q = state_reg.pend_addr[2*HW-1:HW];
        end
        if (release_hold) begin
          finish = 1'b1;
        end
      end
      VPAS_D_EXTEND: begin
        state_next.col_strobe = ext_cas;
        if (ext_cas == '0) begin
          state_next.st = VPAS_D_IDLE;
        end
      end
      default: begin
        state_next.st = VPAS_D_IDLE;
        state_next.row_strobe = '0;
        state_next.col_strobe = '0;
      end
    endcase
    if (finish) begin
      state_next.row_strobe = '0;
      state_next.hold_seen = 1'b0;
      pre_load = 1'b1;
      if (state_reg.cfg.cas_ext_opt | (ext_cas == '0)) begin
        state_next.col_strobe = '0;
        state_next.st = VPAS_D_IDLE;
      end else begin
        state_next.col_strobe = ext_cas;
        state_next.st = VPAS_D_EXTEND;
      end
    end
    state_next.ack = state_reg.cfg.ack_en & (state_next.st == VPAS_D_COL) & (state_next.col_strobe != '0);
    state_next.toe = ~link.write_indicator & ~state_reg.cfg.cas_ext_opt & (state_next.col_strobe != '0);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.st <= VPAS_D_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // outputs
  assign link.row_strobe = state_reg.row_strobe;
  assign link.col_strobe = state_reg.col_strobe;
  assign link.muxed_address_out = state_reg.q;
  assign link.transfer_output_enable = state_reg.toe;
  assign link.transfer_acknowledge = state_reg.ack;
endmodule // vpas_device

/* rtl/vpas_host.sv */
`include "vpas_cfg.svh"

module vpas_host #(
  parameter int HW = 11,
  parameter int NR = 4,
  parameter int NC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // link
  vpas_link_if.host link
);
  import vpas_pkg::*;

  localparam int BW = $clog2(NR);

  typedef struct packed {
    vpas_host_state_t st;
    logic wr;
    logic mode1;
    logic extend;
    logic [31:0] addr;
    logic [7:0] hold_len;
    logic [7:0] hold_cnt;
    logic [7:0] acks;
    logic ack_prev;
    logic strobe;
    logic cs;
    logic hold;
    logic [31:0] rdata;
  } vpas_host_reg_t;

  vpas_host_reg_t state_reg;
  vpas_host_reg_t state_next;

  // ==========================================
  // controller
  always_comb begin
    state_next = state_reg;
    state_next.rdata = '0;
    state_next.ack_prev = link.transfer_acknowledge;
    if (link.transfer_acknowledge & ~state_reg.ack_prev) begin
      state_next.acks = state_reg.acks + 8'h01;
    end
    if (reg_write) begin
      case (reg_addr)
        `VPAS_REG_ADDR: state_next.addr = reg_wdata;
        `VPAS_REG_HOLD: state_next.hold_len = (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
        `VPAS_REG_CTRL: begin
          if (state_reg.st == VPAS_H_IDLE) begin
            state_next.wr = reg_wdata[`VPAS_CTRL_WRITE];
            state_next.mode1 = reg_wdata[`VPAS_CTRL_MODE1];
            state_next.extend = reg_wdata[`VPAS_CTRL_EXTEND];
          end
        end
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        `VPAS_REG_CTRL: begin
          state_next.rdata[`VPAS_CTRL_WRITE] = state_reg.wr;
          state_next.rdata[`VPAS_CTRL_MODE1] = state_reg.mode1;
          state_next.rdata[`VPAS_CTRL_EXTEND] = state_reg.extend;
        end
        `VPAS_REG_ADDR: state_next.rdata = state_reg.addr;
        `VPAS_REG_HOLD: state_next.rdata = {24'h000000, state_reg.hold_len};
        `VPAS_REG_STATUS: begin
          state_next.rdata[`VPAS_STATUS_BUSY] = (state_reg.st != VPAS_H_IDLE);
          state_next.rdata[`VPAS_STATUS_ACKS_LSB +: 8] = state_reg.acks;
        end
        default: state_next.rdata = '0;
      endcase
    end
    case (state_reg.st)
      VPAS_H_IDLE: begin
        // a new access only after the last hold period ended
        if (reg_write & (reg_addr == `VPAS_REG_CTRL) & reg_wdata[`VPAS_CTRL_START]) begin
          state_next.st = VPAS_H_STROBE;
          state_next.cs = 1'b1;
          state_next.strobe = 1'b1;
          state_next.hold = reg_wdata[`VPAS_CTRL_MODE1];
        end
      end
      VPAS_H_STROBE: begin
        state_next.st = VPAS_H_HOLD;
        state_next.strobe = 1'b0;
        state_next.hold = 1'b1;
        state_next.cs = 1'b0;
        state_next.hold_cnt = state_reg.hold_len;
      end
      VPAS_H_HOLD: begin
        if (state_reg.hold_cnt <= 8'h01) begin
          state_next.st = VPAS_H_IDLE;
          state_next.hold = 1'b0;
          state_next.hold_cnt = 8'h00;
        end else begin
          state_next.hold_cnt = state_reg.hold_cnt - 8'h01;
        end
      end
      default: begin
        state_next.st = VPAS_H_IDLE;
        state_next.strobe = 1'b0;
        state_next.cs = 1'b0;
        state_next.hold = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.st <= VPAS_H_IDLE;
      state_reg.hold_len <= `VPAS_HOLD_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // outputs from flip-flops, vram_write_enable an AND of two of them, all clock synchronous
  assign reg_rdata = state_reg.rdata;
  assign link.address_strobe = state_reg.strobe;
  assign link.chip_select = state_reg.cs;
  assign link.access_hold_request = state_reg.hold;
  assign link.write_indicator = state_reg.wr;
  assign link.vram_write_enable = state_reg.wr & state_reg.hold;
  assign link.address = state_reg.addr[2*HW-1:0];
  assign link.bank_select = state_reg.addr[`VPAS_ADDR_BANK_LSB +: BW];
  assign link.byte_select = state_reg.addr[`VPAS_ADDR_BYTE_LSB +: NC];
  assign link.cas_extend_inputs = {NC{state_reg.extend}};
endmodule // vpas_host

/* dv/vpas_props.sv */
module vpas_props #(
  parameter int HW = 11,
  parameter int NR = 4,
  parameter int NC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // host side of link
  input wire logic address_strobe,
  input wire logic chip_select,
  input wire logic access_hold_request,
  input wire logic write_indicator,
  input wire logic vram_write_enable,
  input wire logic [NC-1:0] cas_extend_inputs,
  // device side of link
  input wire logic [NR-1:0] row_strobe,
  input wire logic [NC-1:0] col_strobe,
  input wire logic [HW-1:0] muxed_address_out,
  input wire logic transfer_output_enable,
  input wire logic transfer_acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // link checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_row_onehot; |row_strobe |-> $onehot(row_strobe); endproperty
  a_row_onehot: assert property (p_row_onehot)
    else $error("row strobe not one-hot");
  property p_col_after_row; $rose(|col_strobe) |-> $past(|row_strobe, 4); endproperty
  a_col_after_row: assert property (p_col_after_row)
    else $error("column strobe too soon after row");
  property p_col_addr; $rose(|col_strobe) |-> $stable(muxed_address_out); endproperty
  a_col_addr: assert property (p_col_addr)
    else $error("column address not set up");
  property p_hold_end;
    $fell(access_hold_request) && (|row_strobe) |=> (row_strobe == '0) && !transfer_acknowledge;
  endproperty
  a_hold_end: assert property (p_hold_end)
    else $error("row strobe or acknowledge not ended");
  property p_ack_col; $rose(transfer_acknowledge) |-> $rose(|col_strobe); endproperty
  a_ack_col: assert property (p_ack_col)
    else $error("acknowledge not with column strobe");
  property p_toe; transfer_output_enable |-> (|col_strobe) && !write_indicator; endproperty
  a_toe: assert property (p_toe)
    else $error("output enable without read column strobe");
  property p_ext;
    (row_strobe == '0) && (|col_strobe) |-> (col_strobe & ~$past(cas_extend_inputs)) == '0;
  endproperty
  a_ext: assert property (p_ext)
    else $error("column strobe kept without extend input");
  property p_strobe_cs; address_strobe |-> chip_select; endproperty
  a_strobe_cs: assert property (p_strobe_cs)
    else $error("strobe without select");
  property p_strobe_pulse; address_strobe |=> !address_strobe; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("strobe longer than one cycle");
  property p_hold_follows; address_strobe |=> access_hold_request; endproperty
  a_hold_follows: assert property (p_hold_follows)
    else $error("hold request missing after strobe");
  property p_we; vram_write_enable |-> write_indicator && access_hold_request; endproperty
  a_we: assert property (p_we)
    else $error("write enable outside write access");
endmodule // vpas_props

/* dv/tb_top.sv */
`include "vpas_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vpas_pkg::*;
  logic clk, reset_n, program_load, strap, pipe, cdly, cext, ackopt, rbusy, pbusy, tbusy;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_write, reg_read;
  int bad_count, tests_run, acks, i;
  int seed = 32'h97ae4746;

  // ==========================================
  // design
  vpas_link_if u_vpas_link_if ();
  vpas_device u_vpas_device (.clk(clk), .reset_n(reset_n), .program_load(program_load),
    .mode_select_strap(strap), .pipeline_option(pipe), .column_delay_bit(cdly),
    .cas_extend_option(cext), .ack_option(ackopt), .refresh_busy(rbusy),
    .port_b_busy(pbusy), .transfer_busy(tbusy), .link(u_vpas_link_if.device));
  vpas_host u_vpas_host (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .link(u_vpas_link_if.host));
  vpas_props u_vpas_props (.clk(clk), .reset_n(reset_n),
    .address_strobe(u_vpas_link_if.address_strobe), .chip_select(u_vpas_link_if.chip_select),
    .access_hold_request(u_vpas_link_if.access_hold_request),
    .write_indicator(u_vpas_link_if.write_indicator),
    .vram_write_enable(u_vpas_link_if.vram_write_enable),
    .cas_extend_inputs(u_vpas_link_if.cas_extend_inputs), .row_strobe(u_vpas_link_if.row_strobe),
    .col_strobe(u_vpas_link_if.col_strobe), .muxed_address_out(u_vpas_link_if.muxed_address_out),
    .transfer_output_enable(u_vpas_link_if.transfer_output_enable),
    .transfer_acknowledge(u_vpas_link_if.transfer_acknowledge));

  always #2 clk = ~clk;

  // ==========================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
    @(posedge clk);
  endtask

  task automatic access(input int m1, input int wr, input int cd, input int eo, input int ak);
    int n, s, tr, tc, tf, bl, bank, ext, nb, rt;
    logic [3:0] bytes, rv, cv, ce;
    logic [21:0] adr;
    logic [10:0] qr, qc, qe;
    logic toe, ackv;
    bank = $random(seed) & 3;
    bytes = $random(seed);
    if (bytes == 4'h0) bytes = 4'h1;
    adr = $random(seed);
    ext = $random(seed) & 1;
    nb = $random(seed) & 7;
    {strap, cdly, cext, ackopt, pipe} <= {m1[0], cd[0], eo[0], ak[0], 1'($random(seed))};
    program_load <= 1'b1;
    @(posedge clk);
    program_load <= 1'b0;
    @(posedge clk);
    reg_wr(`VPAS_REG_HOLD, 32'h10);
    reg_wr(`VPAS_REG_ADDR, {4'h0, bytes, bank[1:0], adr});
    if (nb > 4) {tbusy, pbusy, rbusy} <= 3'h1 << (nb - 5);
    reg_addr <= `VPAS_REG_CTRL;
    reg_wdata <= {28'h0, ext[0], m1[0], wr[0], 1'b1};
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    s = -1; tr = -1; tc = -1; tf = -1; bl = -1;
    for (n = 0; n < 80 && tf < 0; n++) begin
      #1;
      if ((rbusy | pbusy | tbusy) === 1'b1) bl = n;
      if (u_vpas_link_if.address_strobe === 1'b1 && s < 0) s = n;
      if (|u_vpas_link_if.row_strobe === 1'b1 && tr < 0) begin
        tr = n;
        rv = u_vpas_link_if.row_strobe;
        qr = u_vpas_link_if.muxed_address_out;
      end
      if (|u_vpas_link_if.col_strobe === 1'b1 && tc < 0) begin
        tc = n;
        cv = u_vpas_link_if.col_strobe;
        qc = u_vpas_link_if.muxed_address_out;
        toe = u_vpas_link_if.transfer_output_enable;
        ackv = u_vpas_link_if.transfer_acknowledge;
      end
      if (tr >= 0 && u_vpas_link_if.row_strobe === 4'h0) begin
        tf = n;
        ce = u_vpas_link_if.col_strobe;
        qe = u_vpas_link_if.muxed_address_out;
      end
      @(posedge clk);
      if (n + 4 >= nb) {tbusy, pbusy, rbusy} <= 3'h0;
    end
    if (tf < 0 || tc < 0 || s < 0) begin
      bad_count++;
      finish_test();
    end
    rt = (bl + 2 > s + 2 - m1) ? bl + 2 : s + 2 - m1;
    check("row_time", tr, rt);
    check("row_strobe", rv, 4'h1 << bank);
    check("row_addr", qr, adr[21:11]);
    check("col_addr", qc, adr[10:0]);
    if (pipe !== 1'b1 || m1 == 0 || nb > 4) begin
      check("col_hold", qe, (pipe === 1'b1) ? adr[21:11] : adr[10:0]);
    end
    check("col_time", tc - tr, `VPAS_ROW_HOLD_CYC + `VPAS_COL_SETUP_CYC + 2 + (wr & cd));
    check("col_strobe", cv, bytes);
    check("toe", toe, (!wr && !eo) ? 1 : 0);
    check("ack", ackv, ak);
    check("end_time", tf - s, 18);
    check("extended", ce, (ext && !eo) ? bytes : 4'h0);
    acks += ak;
    reg_wr(`VPAS_REG_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    check("col_released", u_vpas_link_if.col_strobe, 4'h0);
    reg_rd(`VPAS_REG_STATUS, (acks & 8'hff) << `VPAS_STATUS_ACKS_LSB, "status");
    repeat (12) @(posedge clk);
    #1;
    check("no_repeat", u_vpas_link_if.row_strobe, 4'h0);
  endtask

  // ==========================================
  // sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {program_load, strap, pipe, cdly, cext, ackopt, rbusy, pbusy, tbusy} = '0;
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    bad_count = 0;
    tests_run = 0;
    acks = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    reg_rd(`VPAS_REG_HOLD, `VPAS_HOLD_RST, "hold_reset");
    reg_rd(`VPAS_REG_STATUS, 32'h0, "status_reset");
    reg_wr(`VPAS_REG_HOLD, 32'h0);
    reg_rd(`VPAS_REG_HOLD, 32'h1, "hold_zero");
    reg_wr(4'h2, 32'hffffffff);
    reg_rd(4'h2, 32'h0, "unmapped");
    for (i = 0; i < 32; i++) access(i & 1, (i >> 1) & 1, (i >> 2) & 1, (i >> 3) & 1, (i >> 4) & 1);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    acks = 0;
    reg_rd(`VPAS_REG_STATUS, 32'h0, "status_rerun");
    access(1, 0, 0, 0, 1);
    access(0, 1, 1, 1, 1);
    finish_test();
  end
endmodule // tb_top
